// ### qrb_flash_read.sv
// Quad I/O read path of a serial flash with burst wrap and enhance mode.
// Assumes serial pins arrive asynchronously and the serial clock is much
// slower than pclk; APB slave answers with no wait states.
`timescale 1ns/1ps
`default_nettype none

module qrb_flash_read
    import qrb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  data_line_in,
    output logic      [3:0]  data_line_out,
    output logic      [3:0]  data_line_oe
);

    logic [1:0]  sclk_sync_reg;
    logic [1:0]  cs_sync_reg;
    logic [3:0]  din_s1_reg;
    logic [3:0]  din_s2_reg;
    logic        sclk_d_reg;
    logic        cs_d_reg;

    logic [15:0] ctrl_reg;
    logic [7:0]  maddr_reg;
    logic [7:0]  mem_reg [QRB_MEM_DEPTH];

    qrb_state_t  state_reg;
    logic [3:0]  cnt_reg;
    logic [31:0] shift_reg;
    logic        wide_reg;
    logic        quad_reg;
    logic [31:0] addr_reg;
    logic        nib_hi_reg;
    logic        enh_reg;
    logic        enh_wide_reg;
    logic        enh_exit_reg;
    logic        wrap_en_reg;
    logic [1:0]  wrap_depth_reg;
    logic [7:0]  last_op_reg;

    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [3:0]  dout_reg;
    logic [3:0]  doe_reg;

    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        sel;
    logic [31:0] shift_next;
    logic [3:0]  cnt_next;
    logic [3:0]  dummy_n;
    logic [7:0]  ind_byte;

    // Merge one sample into the shift register: a nibble or a single bit
    function automatic logic [31:0] shift_in(input logic [31:0] cur,
                                             input logic [3:0]  din,
                                             input logic        quad);
        shift_in = quad ? {cur[27:0], din} : {cur[30:0], din[0]};
    endfunction

    // Next read address, wrapping inside the selected aligned unit
    function automatic logic [31:0] next_addr(input logic [31:0] a,
                                              input logic        wrap,
                                              input logic [1:0]  depth);
        logic [31:0] mask;
        mask = 32'h7 >> 0;
        case (depth)
            2'h0:    mask = 32'h0000_0007;
            2'h1:    mask = 32'h0000_000f;
            2'h2:    mask = 32'h0000_001f;
            default: mask = 32'h0000_003f;
        endcase
        if (wrap) begin
            next_addr = (a & ~mask) | ((a + 32'h1) & mask);
        end else begin
            next_addr = a + 32'h1;
        end
    endfunction

    // Pin synchronisers; the first stage only feeds the second, edges use the second stage and its delayed copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync_reg <= 2'h0;
            cs_sync_reg   <= 2'h3;
            din_s1_reg    <= 4'h0;
            din_s2_reg    <= 4'h0;
            sclk_d_reg    <= 1'b0;
            cs_d_reg      <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], sclk};
            cs_sync_reg   <= {cs_sync_reg[0], cs_n};
            din_s1_reg    <= data_line_in;
            din_s2_reg    <= din_s1_reg;
            sclk_d_reg    <= sclk_sync_reg[1];
            cs_d_reg      <= cs_sync_reg[1];
        end
    end

    assign sel       = ~cs_sync_reg[1];
    assign sclk_rise = sel & sclk_sync_reg[1] & ~sclk_d_reg;
    assign sclk_fall = sel & ~sclk_sync_reg[1] & sclk_d_reg;
    assign cs_fall   = ~cs_sync_reg[1] & cs_d_reg;
    assign cs_rise   = cs_sync_reg[1] & ~cs_d_reg;
    assign cnt_next  = cnt_reg + 4'h1;
    assign shift_next = shift_in(shift_reg, din_s2_reg, quad_reg);
    assign ind_byte  = shift_next[7:0];

    always_comb begin
        case (ctrl_reg[QRB_CTRL_DC_HI:QRB_CTRL_DC_LO])
            2'h0:    dummy_n = QRB_DUMMY_DC00;
            2'h1:    dummy_n = QRB_DUMMY_DC01;
            2'h2:    dummy_n = QRB_DUMMY_DC10;
            default: dummy_n = QRB_DUMMY_DC11;
        endcase
    end

    // Serial protocol state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= QRB_IDLE;
            cnt_reg     <= 4'h0;
            shift_reg   <= 32'h0;
            wide_reg    <= 1'b0;
            quad_reg    <= 1'b0;
            last_op_reg <= 8'h00;
        end else if (!sel) begin
            state_reg <= QRB_IDLE;
            cnt_reg   <= 4'h0;
        end else if (cs_fall) begin
            cnt_reg   <= 4'h0;
            shift_reg <= 32'h0;
            if (enh_reg) begin
                state_reg <= QRB_ADDR;
                wide_reg  <= enh_wide_reg;
                quad_reg  <= 1'b1;
            end else begin
                state_reg <= QRB_CMD;
                quad_reg  <= ctrl_reg[QRB_CTRL_QCM];
            end
        end else if (sclk_rise) begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            case (state_reg)
                QRB_CMD: begin
                    if (cnt_next == (quad_reg ? QRB_BYTE_QPI : QRB_BYTE_SPI)) begin
                        cnt_reg     <= 4'h0;
                        last_op_reg <= shift_next[7:0];
                        case (shift_next[7:0])
                            QRB_OP_READ_EA, QRB_OP_READ_EB, QRB_OP_READ_EC: begin
                                if (ctrl_reg[QRB_CTRL_BUSY] ||
                                    !(ctrl_reg[QRB_CTRL_QE] || quad_reg)) begin
                                    state_reg <= QRB_IGNORE;
                                end else begin
                                    state_reg <= QRB_ADDR;
                                    quad_reg  <= 1'b1;
                                    wide_reg  <= ctrl_reg[QRB_CTRL_WIDE] ||
                                                 (shift_next[7:0] == QRB_OP_READ_EC);
                                end
                            end
                            QRB_OP_BURST: state_reg <= QRB_BURST;
                            default:      state_reg <= QRB_IGNORE;
                        endcase
                    end
                end
                QRB_ADDR: begin
                    if (cnt_next == (wide_reg ? QRB_ADDR4_CLKS : QRB_ADDR3_CLKS)) begin
                        state_reg <= QRB_DUMMY;
                        cnt_reg   <= 4'h0;
                    end
                end
                QRB_DUMMY: begin
                    if (cnt_next == dummy_n) begin
                        state_reg <= QRB_DATA;
                        cnt_reg   <= 4'h0;
                    end
                end
                QRB_BURST: begin
                    if (cnt_next == (quad_reg ? QRB_BYTE_QPI : QRB_BYTE_SPI)) begin
                        state_reg <= QRB_IGNORE;
                        cnt_reg   <= 4'h0;
                    end
                end
                QRB_DATA:   cnt_reg <= 4'h0;
                QRB_IGNORE: cnt_reg <= 4'h0;
                default:    state_reg <= QRB_IGNORE;
            endcase
        end
    end

    // Wrap configuration; survives reads until reset or a reset opcode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_en_reg    <= 1'b0;
            wrap_depth_reg <= 2'h0;
        end else if (sel && sclk_rise && state_reg == QRB_CMD &&
                     cnt_next == (quad_reg ? QRB_BYTE_QPI : QRB_BYTE_SPI) &&
                     shift_next[7:0] == QRB_OP_RESET) begin
            wrap_en_reg <= 1'b0;
        end else if (sel && sclk_rise && state_reg == QRB_BURST &&
                     cnt_next == (quad_reg ? QRB_BYTE_QPI : QRB_BYTE_SPI)) begin
            wrap_en_reg    <= (shift_next[7:4] == 4'h0);
            wrap_depth_reg <= shift_next[1:0];
        end
    end

    // Enhance mode: armed by a complementary indicator, dropped at the select rise after a non-complementary one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enh_reg      <= 1'b0;
            enh_wide_reg <= 1'b0;
            enh_exit_reg <= 1'b0;
        end else if (cs_rise) begin
            if (enh_exit_reg || state_reg == QRB_ADDR || state_reg == QRB_CMD) begin
                enh_reg <= 1'b0;
            end
            enh_exit_reg <= 1'b0;
        end else if (sel && sclk_rise && state_reg == QRB_CMD &&
                     cnt_next == (quad_reg ? QRB_BYTE_QPI : QRB_BYTE_SPI) &&
                     shift_next[7:0] == QRB_OP_RESET) begin
            enh_reg <= 1'b0;
        end else if (sel && sclk_rise && state_reg == QRB_DUMMY &&
                     cnt_next == QRB_IND_CLKS) begin
            if (ind_byte[7:4] == ~ind_byte[3:0]) begin
                enh_reg      <= 1'b1;
                enh_wide_reg <= wide_reg;
                enh_exit_reg <= 1'b0;
            end else begin
                enh_exit_reg <= 1'b1;
            end
        end
    end

    // Read address loaded on a rising serial clock edge; advance and nibble output on falling edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg   <= 32'h0;
            nib_hi_reg <= 1'b1;
            dout_reg   <= 4'h0;
            doe_reg    <= 4'h0;
        end else if (!sel) begin
            doe_reg    <= 4'h0;
            nib_hi_reg <= 1'b1;
        end else if (sclk_rise && state_reg == QRB_ADDR &&
                     cnt_next == (wide_reg ? QRB_ADDR4_CLKS : QRB_ADDR3_CLKS)) begin
            // Narrow mode takes its top byte from the extended address field
            addr_reg <= wide_reg ? shift_next :
                        {ctrl_reg[QRB_CTRL_EXT_LO +: 8], shift_next[23:0]};
            nib_hi_reg <= 1'b1;
        end else if (sclk_fall && state_reg == QRB_DATA) begin
            doe_reg <= 4'hf;
            if (nib_hi_reg) begin
                dout_reg   <= mem_reg[addr_reg[QRB_MEM_AW-1:0]][7:4];
                nib_hi_reg <= 1'b0;
            end else begin
                dout_reg   <= mem_reg[addr_reg[QRB_MEM_AW-1:0]][3:0];
                nib_hi_reg <= 1'b1;
                addr_reg   <= next_addr(addr_reg, wrap_en_reg, wrap_depth_reg);
            end
        end
    end

    // APB: decode in the setup cycle so data is ready in the access cycle
    logic setup_phase;
    logic access_wr;
    assign setup_phase = psel & ~penable;
    assign access_wr   = psel & penable & pwrite & pready_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (setup_phase) begin
                pslverr_reg <= 1'b0;
                prdata_reg  <= 32'h0;
                case (paddr)
                    QRB_OFF_CTRL:   prdata_reg <= {16'h0, ctrl_reg};
                    QRB_OFF_STATUS: prdata_reg <= {last_op_reg, 13'h0, state_reg,
                                                   2'h0, wrap_depth_reg, wrap_en_reg,
                                                   enh_wide_reg, enh_reg, sel};
                    QRB_OFF_MADDR:  prdata_reg <= {24'h0, maddr_reg};
                    QRB_OFF_MDATA:  prdata_reg <= {24'h0, mem_reg[maddr_reg]};
                    default:        pslverr_reg <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= QRB_CTRL_RST;
        end else if (access_wr && paddr == QRB_OFF_CTRL) begin
            ctrl_reg <= pwdata[15:0];
        end
    end

    // Array writes auto-increment the index so software can stream a load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            maddr_reg <= 8'h00;
        end else if (access_wr && paddr == QRB_OFF_MADDR) begin
            maddr_reg <= pwdata[7:0];
        end else if (access_wr && paddr == QRB_OFF_MDATA) begin
            maddr_reg <= maddr_reg + 8'h01;
        end
    end

    // Array contents are left untouched by any serial access
    always_ff @(posedge pclk) begin
        if (access_wr && paddr == QRB_OFF_MDATA) begin
            mem_reg[maddr_reg] <= pwdata[7:0];
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign data_line_out = dout_reg;
    assign data_line_oe  = doe_reg;

endmodule // qrb_flash_read

`default_nettype wire

// ### qrb_pkg.sv
// Constants, opcodes and register map of the quad I/O read path.
// Assumes one pclk domain; every serial pin is synchronised before use.
//
// Overview of operation
// - Address sampled on serial clock rise, data driven on fall, four bits each.
// - Read address advances after each byte and rolls over to zero.
// - After the quad read opcode, address, dummy and data use four lines.
// - Three-byte address by default; four bytes in wide mode or with ECh.
// - Single-line opcode, quad address, six dummy clocks, data until select rises.
// - In quad command mode the opcode itself also travels on four lines.
// - A quad read during program, erase or status write is ignored; enhance-mode frames skip this busy check.
// - Dummy clock count follows configuration bits 6 and 7.
// - Wide-address variants always take a 32-bit address.
// - Burst setting opcode C0h, then a wrap nibble: 0h enables, 1h disables.
// - Depth nibble 0..3 gives 8, 16, 32, 64 bytes; 1xh disables wrapping.
// - Wrapping stays inside its aligned unit; disabled after reset.
// - Wrap setting persists until reset; later burst commands change it.
// - Reads EAh and EBh wrap when enabled, in both command modes.
// - Enhance mode exists for EAh, EBh and ECh only, never dual reads.
// - Complementary nibbles in the indicator byte enter or keep enhance mode.
// - Non-complementary indicator then a select pulse leaves enhance mode.
// - In enhance mode the next select-low starts directly with the address.
// - Enhance sequence: address, indicator, four dummy clocks, data.
package qrb_pkg;

    localparam int          QRB_MEM_DEPTH   = 256;
    localparam int          QRB_MEM_AW      = 8;

    localparam logic [7:0]  QRB_OP_READ_EA  = 8'hea;
    localparam logic [7:0]  QRB_OP_READ_EB  = 8'heb;
    localparam logic [7:0]  QRB_OP_READ_EC  = 8'hec;
    localparam logic [7:0]  QRB_OP_BURST    = 8'hc0;
    localparam logic [7:0]  QRB_OP_RESET    = 8'h99;

    // Dummy clocks include the two indicator clocks
    localparam logic [3:0]  QRB_DUMMY_DC00  = 4'h6;
    localparam logic [3:0]  QRB_DUMMY_DC01  = 4'h4;
    localparam logic [3:0]  QRB_DUMMY_DC10  = 4'h8;
    localparam logic [3:0]  QRB_DUMMY_DC11  = 4'ha;
    localparam logic [3:0]  QRB_IND_CLKS    = 4'h2;
    localparam logic [3:0]  QRB_ADDR3_CLKS  = 4'h6;
    localparam logic [3:0]  QRB_ADDR4_CLKS  = 4'h8;
    localparam logic [3:0]  QRB_BYTE_SPI    = 4'h8;
    localparam logic [3:0]  QRB_BYTE_QPI    = 4'h2;

    localparam logic [7:0]  QRB_OFF_CTRL    = 8'h00;
    localparam logic [7:0]  QRB_OFF_STATUS  = 8'h04;
    localparam logic [7:0]  QRB_OFF_MADDR   = 8'h08;
    localparam logic [7:0]  QRB_OFF_MDATA   = 8'h0c;

    localparam int          QRB_CTRL_QE     = 0;
    localparam int          QRB_CTRL_QCM    = 1;
    localparam int          QRB_CTRL_WIDE   = 2;
    localparam int          QRB_CTRL_BUSY   = 3;
    localparam int          QRB_CTRL_DC_LO  = 6;
    localparam int          QRB_CTRL_DC_HI  = 7;
    localparam int          QRB_CTRL_EXT_LO = 8;
    localparam logic [15:0] QRB_CTRL_RST    = 16'h0000;

    typedef enum logic [2:0] {
        QRB_IDLE   = 3'b000,
        QRB_CMD    = 3'b001,
        QRB_ADDR   = 3'b011,
        QRB_DUMMY  = 3'b010,
        QRB_DATA   = 3'b110,
        QRB_BURST  = 3'b111,
        QRB_IGNORE = 3'b101
    } qrb_state_t;

endpackage

// ### qrb_flash_read_chk.sv
// Pin checker for the quad read block: APB answers and serial output timing.
// Bound to qrb_flash_read; CTRL busy is changed only while select is high.
`timescale 1ns/1ps
`default_nettype none
module qrb_flash_read_chk
    import qrb_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic [3:0]  data_line_in,
    input wire logic [3:0]  data_line_out,
    input wire logic [3:0]  data_line_oe
);
    logic       sclk_q;
    logic       busy_q;
    logic [3:0] fall_cnt;
    // Cycles since the last serial clock fall, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q   <= 1'b0;
            fall_cnt <= 4'hf;
        end else begin
            sclk_q   <= sclk;
            fall_cnt <= (sclk_q && !sclk) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hf};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            busy_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == QRB_OFF_CTRL)
            busy_q <= pwdata[QRB_CTRL_BUSY];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_lanes_together: assert property (data_line_oe == 4'h0 || data_line_oe == 4'hf)
        else $error("data lines enabled apart");
    a_release_deselect: assert property (cs_n [*6] |-> data_line_oe == 4'h0)
        else $error("data lines driven while deselected");
    a_drive_on_fall: assert property (data_line_oe[0] && $past(data_line_oe[0])
        && $changed(data_line_out) |-> fall_cnt <= 4'h6)
        else $error("output nibble changed away from a clock fall");
    a_start_on_fall: assert property ($rose(data_line_oe[0]) |-> fall_cnt <= 4'h6 && !cs_n)
        else $error("output started away from a clock fall");
    a_hold_selected: assert property (!cs_n [*5] ##0 data_line_oe[0] |=> data_line_oe[0])
        else $error("output dropped while selected");
    a_busy_silent: assert property (busy_q |-> data_line_oe == 4'h0)
        else $error("read answered while busy");
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("access phase not ready");
    a_unmapped_err: assert property (psel && penable && paddr[7:4] != 4'h0
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (psel && penable && paddr == QRB_OFF_MADDR |-> !pslverr)
        else $error("mapped access flagged");
    c_data_out: cover property ($rose(data_line_oe[0]));
    c_slv_err: cover property (psel && penable && pslverr);
    c_busy_sel: cover property (busy_q && !cs_n);
endmodule // qrb_flash_read_chk
`default_nettype wire

// ### qrb_host_model.sv
// Host flash controller model: drives select, serial clock and data lines.
// Steps on pclk edges; undriven lines show an inverted, toggling pattern.
`timescale 1ns/1ps
`default_nettype none
module qrb_host_model (
    input  wire logic       pclk,
    input  wire logic       slow,
    input  wire logic [3:0] dev_out,
    input  wire logic [3:0] dev_oe,
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      line,
    output logic            byte_stb,
    output logic [7:0]      byte_val
);
    logic [3:0] drv = 4'h0;
    logic [3:0] hen = 4'h0;
    logic [3:0] last = 4'h0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        byte_stb = 1'b0;
        byte_val = 8'h00;
    end
    assign line = (drv & hen) | (dev_out & dev_oe & ~hen) | (~last & ~dev_oe & ~hen);
    always @(posedge pclk) last <= line;
    // Drive on the fall, sample what the device put out before this fall
    task automatic tick(input logic [3:0] nib, input logic [3:0] en,
                        output logic [3:0] smp, output bit ok);
        @(posedge pclk);
        smp = line;
        ok = (dev_oe == 4'hf);
        sclk <= 1'b0;
        drv <= nib;
        hen <= en;
        repeat (slow ? 7 : 4) @(posedge pclk);
        sclk <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    task automatic shift(input int n, input logic [31:0] v, input bit q);
        logic [3:0] s;
        bit k;
        for (int i = n - 1; i >= 0; i--)
            tick(q ? v[4*i+:4] : {3'h0, v[i]}, q ? 4'hf : 4'h1, s, k);
    endtask
    task automatic end_frame;
        @(posedge pclk);
        sclk <= 1'b0;
        hen <= 4'h0;
        @(posedge pclk);
        cs_n <= 1'b1;
        repeat (5) @(posedge pclk);
    endtask
    task automatic cmd(input int n, input logic [31:0] v, input bit q);
        @(posedge pclk);
        cs_n <= 1'b0;
        shift(n, v, q);
        end_frame;
    endtask
    task automatic frame(input logic [7:0] op, input bit q, input bit skip, input int an,
                         input logic [31:0] a, input logic [7:0] ind, input int dum,
                         input int nb);
        logic [3:0] s;
        logic [3:0] hi;
        bit k;
        bit ok;
        @(posedge pclk);
        cs_n <= 1'b0;
        if (!skip)
            shift(q ? 2 : 8, {24'h0, op}, q);
        shift(an, a, 1'b1);
        shift(2, {24'h0, ind}, 1'b1);
        for (int i = 2; i < dum; i++)
            tick(4'h0, 4'h0, s, k);
        ok = 1'b0;
        for (int i = 0; i <= 2 * nb; i++) begin
            tick(4'h0, 4'h0, s, k);
            if (i % 2 == 1) begin
                hi = s;
                ok = k;
            end else if (i > 0 && ok && k) begin
                byte_val <= {hi, s};
                byte_stb <= 1'b1;
                @(posedge pclk) byte_stb <= 1'b0;
            end
        end
        end_frame;
    endtask
endmodule // qrb_host_model
`default_nettype wire

// ### qrb_flash_read_bench.sv
// Self-checking bench: loads the array over APB, then runs host read frames.
// Expected bytes are queued by the driver and compared as the host receives them.
`timescale 1ns/1ps
`default_nettype none
module qrb_flash_read_bench
    import qrb_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic slow = 1'b0, err, sclk, cs_n, pready, pslverr, byte_stb;
    logic [7:0] paddr = 8'h00, byte_val;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd5551;
    logic [3:0] data_line_in, data_line_out, data_line_oe;
    logic [7:0] mem [256];
    logic [7:0] expq [$];
    int error_cnt = 0, n_checks = 0;
    int dums [4] = '{QRB_DUMMY_DC00, QRB_DUMMY_DC01, QRB_DUMMY_DC10, QRB_DUMMY_DC11};
    always #10 pclk = ~pclk;
    qrb_flash_read dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sclk, .cs_n, .data_line_in, .data_line_out, .data_line_oe);
    qrb_host_model host (.pclk, .slow, .dev_out(data_line_out), .dev_oe(data_line_oe),
        .sclk, .cs_n, .line(data_line_in), .byte_stb, .byte_val);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 50) begin
            check(t, 0, "apb timeout");
            tally_and_finish;
        end
    endtask
    task automatic rdx(input logic [7:0] op, input bit q, input bit skip, input int an,
                       input logic [31:0] a, input logic [7:0] ind, input int dum,
                       input int nb, input logic [31:0] wl);
        logic [31:0] b;
        for (int i = 0; i < nb; i++) begin
            b = wl == 0 ? a + i : (a & ~(wl - 1)) | ((a + i) & (wl - 1));
            expq.push_back(mem[b[7:0]]);
        end
        host.frame(op, q, skip, an, a, ind, dum, nb);
        check(expq.size(), 0, "bytes missing");
    endtask
    always @(posedge pclk) begin
        if (byte_stb === 1'b1) begin
            if (expq.size() == 0)
                check({24'h0, byte_val}, 32'h100, "unexpected byte");
            else
                check({24'h0, byte_val}, {24'h0, expq.pop_front()}, "read byte");
        end
    end
    initial begin
        repeat (60000) @(posedge pclk);
        check(0, 1, "run timeout");
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, QRB_OFF_CTRL, 32'h0);
        check(rd, {16'h0, QRB_CTRL_RST}, "ctrl reset");
        apb(1'b1, 8'h40, 32'h1);
        check({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, QRB_OFF_MADDR, 32'h0);
        for (int i = 0; i < 256; i++) begin
            seed = xs(seed);
            mem[i] = seed[7:0];
            apb(1'b1, QRB_OFF_MDATA, {24'h0, seed[7:0]});
        end
        host.frame(QRB_OP_READ_EB, 0, 0, 6, seed, 8'h00, 6, 2);
        apb(1'b1, QRB_OFF_CTRL, 32'h1);
        apb(1'b0, QRB_OFF_CTRL, 32'h0);
        check(rd, 32'h1, "ctrl readback");
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, QRB_OFF_CTRL, {24'h0, d[1:0], 6'h1});
            seed = xs(seed);
            slow = d[0];
            rdx(QRB_OP_READ_EB, 0, 0, 6, seed, 8'h00, dums[d], 3, 0);
        end
        slow = 1'b0;
        apb(1'b1, QRB_OFF_CTRL, 32'h3);
        rdx(QRB_OP_READ_EA, 1, 0, 6, seed, 8'h00, 6, 2, 0);
        apb(1'b1, QRB_OFF_CTRL, 32'h5);
        rdx(QRB_OP_READ_EB, 0, 0, 8, seed, 8'h00, 6, 2, 0);
        apb(1'b1, QRB_OFF_CTRL, 32'h9);
        host.frame(QRB_OP_READ_EB, 0, 0, 6, seed, 8'h00, 6, 2);
        apb(1'b1, QRB_OFF_CTRL, 32'h1);
        rdx(QRB_OP_READ_EC, 0, 0, 8, 32'hfffffffe, 8'h00, 6, 4, 0);
        for (int d = 0; d < 4; d++) begin
            host.cmd(16, {16'h0, QRB_OP_BURST, 6'h0, d[1:0]}, 0);
            seed = xs(seed);
            rdx(QRB_OP_READ_EB, 0, 0, 6, seed, 8'h00, 6, (8 << d) + 2, 8 << d);
        end
        apb(1'b1, QRB_OFF_CTRL, 32'h3);
        host.cmd(4, {16'h0, QRB_OP_BURST, 8'h01}, 1);
        rdx(QRB_OP_READ_EA, 1, 0, 6, seed, 8'h00, 6, 18, 16);
        host.cmd(4, {16'h0, QRB_OP_BURST, 8'h10}, 1);
        rdx(QRB_OP_READ_EB, 1, 0, 6, seed, 8'h00, 6, 18, 0);
        apb(1'b1, QRB_OFF_CTRL, 32'h1);
        host.cmd(16, {16'h0, QRB_OP_BURST, 8'h00}, 0);
        host.cmd(8, {24'h0, QRB_OP_RESET}, 0);
        rdx(QRB_OP_READ_EB, 0, 0, 6, 32'h5, 8'h00, 6, 10, 0);
        rdx(QRB_OP_READ_EB, 0, 0, 6, seed, 8'ha5, 6, 2, 0);
        rdx(QRB_OP_READ_EB, 0, 1, 6, seed + 9, 8'h5a, 6, 2, 0);
        rdx(QRB_OP_READ_EB, 0, 1, 6, seed + 3, 8'hff, 6, 2, 0);
        rdx(QRB_OP_READ_EB, 0, 0, 6, seed, 8'hf0, 6, 2, 0);
        host.cmd(8, 32'hff, 0);
        rdx(QRB_OP_READ_EC, 0, 0, 8, seed, 8'h0f, 6, 2, 0);
        rdx(QRB_OP_READ_EC, 0, 1, 8, seed + 7, 8'h00, 6, 2, 0);
        host.cmd(10, 32'h3ff, 0);
        rdx(QRB_OP_READ_EB, 0, 0, 6, seed, 8'h00, 6, 1, 0);
        tally_and_finish;
    end
endmodule // qrb_flash_read_bench
bind qrb_flash_read qrb_flash_read_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sclk, .cs_n, .data_line_in,
    .data_line_out, .data_line_oe);
`default_nettype wire
